// ---- hw/psr_consts.svh ----
// Purpose: offsets, masks, reset values and timing counts for the pin glue
// Assumes: 100 MHz reference clock
// Notes:   definitions only
`ifndef PSR_CONSTS_SVH
`define PSR_CONSTS_SVH

// reference clock and timing
`define PSR_REF_CLK_MHZ   100
`define PSR_RST_HOLD_NS   640
`define PSR_RST_HOLD_CYC  ((`PSR_RST_HOLD_NS * `PSR_REF_CLK_MHZ + 999) / 1000)
`define PSR_PIN_FILT_CYC  3

// port b line capabilities, one bit per line
`define PSR_PB_CAP1       5'h01
`define PSR_PB_CMP1       5'h02
`define PSR_PB_CAP2       5'h04
`define PSR_PB_CMP2       5'h08
`define PSR_PB_PWM        5'h10

// port c line capabilities, one bit per line
`define PSR_PC_CAP1       7'h11
`define PSR_PC_CMP1       7'h33
`define PSR_PC_CAP2       7'h04
`define PSR_PC_CMP2       7'h08
`define PSR_PC_PWM        7'h71

// port a lines tied to the op amp (output, inverting, non-inverting)
`define PSR_PA_OPAMP      8'h70

// reset values
`define PSR_PA_RST        8'h00
`define PSR_PB_RST        5'h00
`define PSR_PC_RST        7'h00

// 16k address map region ends
`define PSR_IO_END        14'h002F
`define PSR_EXT_END       14'h003F
`define PSR_RAM_END       14'h00FF
`define PSR_GAP1_END      14'h017F
`define PSR_EE_END        14'h01FF
`define PSR_GAP2_END      14'h1FFF
`define PSR_OPT_ADDR      14'h2000
`define PSR_PROG_END      14'h3EFF
`define PSR_MON_END       14'h3FEF

`endif

// ---- hw/psr_pkg.sv ----
// Purpose: types shared by the pin glue modules
// Assumes: nothing
// Notes:   constants live in psr_consts.svh
package psr_pkg;

  typedef enum logic [1:0] {PORT_A, PORT_B, PORT_C} psr_port_t;

  typedef enum logic [1:0] {IRQ_RISE, IRQ_FALL, IRQ_HIGH, IRQ_LOW} psr_irq_mode_t;

  typedef enum logic [3:0] {
    RG_IO, RG_EXT, RG_RAM, RG_GAP, RG_EEPROM, RG_OPTION, RG_PROGRAM, RG_MONITOR, RG_VECTOR
  } psr_region_t;

  typedef struct packed {
    logic      valid;
    logic      to_dir;
    psr_port_t port;
    logic [7:0] value;
  } psr_port_wr_t;

  typedef struct packed {
    logic [7:0] pa_analog;
    logic       opamp_en;
    logic [4:0] pb_timer;
    logic [4:0] pb_pwm;
    logic [6:0] pc_timer;
    logic [6:0] pc_pwm;
  } psr_alt_cfg_t;

  typedef struct packed {
    logic compare_output_1;
    logic compare_output_2;
    logic pwm;
  } psr_periph_t;

  typedef struct packed {
    logic por;
    logic watchdog;
    logic high_voltage;
    logic low_voltage;
    logic high_temp;
    logic clock_fail;
  } psr_rst_src_t;

  typedef struct packed {
    logic stop_en;
    logic watchdog_en;
    logic clk_mon_en;
    logic ht_rst_en;
    logic hv_rst_en;
  } psr_mask_opt_t;

endpackage : psr_pkg

// ---- hw/psr_irq_sense.sv ----
// Purpose: external interrupt pin sensitivity, edge or level
// Assumes: pin sampled synchronously to i_ref_clk
// Notes:   small filter stands in for the pin hysteresis
`timescale 1ns/1ps
`include "psr_consts.svh"

module psr_irq_sense
  import psr_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_irq_pin,
  input  wire psr_irq_mode_t i_mode,
  output logic               o_irq_req
);

  logic       filt_reg;
  logic       prev_reg;
  logic [1:0] cnt_reg;
  logic       req_next;

  assign req_next = (i_mode == IRQ_RISE) ? (filt_reg & ~prev_reg) :
                    (i_mode == IRQ_FALL) ? (~filt_reg & prev_reg) :
                    (i_mode == IRQ_HIGH) ? filt_reg : ~filt_reg;

  // noise filter: flips only after a run of differing samples
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      filt_reg  <= 1'b1;
      prev_reg  <= 1'b1;
      cnt_reg   <= 2'h0;
      o_irq_req <= 1'b0;
    end else begin
      prev_reg  <= filt_reg;
      o_irq_req <= req_next;
      if (i_irq_pin == filt_reg) begin
        cnt_reg <= 2'h0;
      end else if (cnt_reg == 2'(`PSR_PIN_FILT_CYC - 1)) begin
        cnt_reg  <= 2'h0;
        filt_reg <= i_irq_pin;
      end else begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end

  chk_irq_rise_pulse : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_mode == IRQ_RISE) && filt_reg && !prev_reg |=> o_irq_req)
    else $error("rising edge produced no request");

  chk_irq_low_level : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_mode == IRQ_LOW) && !filt_reg && $stable(i_mode) |=> o_irq_req)
    else $error("low level produced no request");

endmodule : psr_irq_sense

// ---- hw/psr_glue.sv ----
// Purpose: chip glue - clock halving, reset pin, irq sense, port sharing, map decode
// Assumes: all pins sampled synchronously to i_ref_clk; oscillator is i_ref_clk
// Notes:   output enables are active low; pin levels resolved outside
//
// Functional notes
// - the internal clock is the oscillator divided by two.
// - a low reset pin, after its noise filter, puts the chip in its start-up state.
// - any internal reset source pulls the reset pin low.
// - the irq pin senses a rising edge, falling edge, high level or low level.
// - all eight port a lines come up as inputs and each direction is set later.
// - port a lines serve the converter and three of them the op amp.
// - port b lines come up as inputs and lines 0 to 3 carry timer capture and compare.
// - port b line 4 may carry the pwm output.
// - port c lines come up as inputs and lines 0 to 5 carry timer capture and compare.
// - port c lines 0 and 4 to 6 may carry pwm and lines 5 and 6 drive relays.
// - stop, watchdog, clock monitor, high temperature and high voltage options exist.
// - a 16k byte address space is decoded into its regions.
`timescale 1ns/1ps
`include "psr_consts.svh"

module psr_glue
  import psr_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_reset_pin_in,
  input  wire psr_rst_src_t  i_rst_src,
  input  wire psr_mask_opt_t i_mask_opt,
  input  wire logic          i_irq_pin,
  input  wire psr_irq_mode_t i_irq_mode,
  input  wire psr_port_wr_t  i_port_wr,
  input  wire psr_alt_cfg_t  i_alt_cfg,
  input  wire psr_periph_t   i_periph,
  input  wire logic [7:0]    i_pa_in,
  input  wire logic [4:0]    i_pb_in,
  input  wire logic [6:0]    i_pc_in,
  input  wire logic          i_cpu_addr_valid,
  input  wire logic [13:0]   i_cpu_addr,
  output logic               o_int_clk,
  output logic               o_reset_pin_out,
  output logic               o_reset_pin_oe_n,
  output logic               o_sys_rst_n,
  output logic               o_irq_req,
  output psr_mask_opt_t      o_mask_opt,
  output logic [7:0]         o_pa_out,
  output logic [7:0]         o_pa_oe_n,
  output logic [7:0]         o_pa_analog_en,
  output logic [4:0]         o_pb_out,
  output logic [4:0]         o_pb_oe_n,
  output logic [6:0]         o_pc_out,
  output logic [6:0]         o_pc_oe_n,
  output logic               o_capture_input_1,
  output logic               o_capture_input_2,
  output psr_region_t        o_region,
  output logic               o_addr_illegal
);

  // pin drive choice: returns {drive enable, value}; pwm beats timer beats gpio
  function automatic logic [1:0] line_drive(input logic dir, input logic val,
                                            input logic tsel, input logic psel,
                                            input logic has_cmp, input logic has_cap,
                                            input logic has_pwm, input logic cmp,
                                            input logic pwm);
    logic [1:0] r;
    r = {dir, val};
    if (psel && has_pwm) begin
      r = {1'b1, pwm};
    end else if (tsel && has_cmp && (dir || !has_cap)) begin
      r = {1'b1, cmp};
    end else if (tsel && has_cap) begin
      r = 2'b00;
    end
    return r;
  endfunction : line_drive

  // 16k map region lookup
  function automatic psr_region_t region_of(input logic [13:0] a);
    psr_region_t r;
    if (a <= `PSR_IO_END) begin
      r = RG_IO;
    end else if (a <= `PSR_EXT_END) begin
      r = RG_EXT;
    end else if (a <= `PSR_RAM_END) begin
      r = RG_RAM;
    end else if (a <= `PSR_GAP1_END) begin
      r = RG_GAP;
    end else if (a <= `PSR_EE_END) begin
      r = RG_EEPROM;
    end else if (a <= `PSR_GAP2_END) begin
      r = RG_GAP;
    end else if (a == `PSR_OPT_ADDR) begin
      r = RG_OPTION;
    end else if (a <= `PSR_PROG_END) begin
      r = RG_PROGRAM;
    end else if (a <= `PSR_MON_END) begin
      r = RG_MONITOR;
    end else begin
      r = RG_VECTOR;
    end
    return r;
  endfunction : region_of

  psr_mask_opt_t opt_reg;
  logic          pin_filt_reg;
  logic [1:0]    pin_cnt_reg;
  logic [6:0]    hold_reg;
  logic [6:0]    hold_next;
  logic          int_src;
  logic          drive_next;
  logic          sys_rst_next;
  logic          port_clr;
  logic [7:0]    dir_a_reg;
  logic [7:0]    dat_a_reg;
  logic [4:0]    dir_b_reg;
  logic [4:0]    dat_b_reg;
  logic [6:0]    dir_c_reg;
  logic [6:0]    dat_c_reg;
  logic [7:0]    analog_next;
  logic [4:0]    pb_drv;
  logic [4:0]    pb_val;
  logic [6:0]    pc_drv;
  logic [6:0]    pc_val;
  logic [4:0]    pb_cap1_act;
  logic [4:0]    pb_cap2_act;
  logic [6:0]    pc_cap1_act;
  logic [6:0]    pc_cap2_act;
  logic          cap1_next;
  logic          cap2_next;
  psr_region_t   region_now;
  logic          illegal_now;
  logic          wr_a;
  logic          wr_b;
  logic          wr_c;

  // address decode; gap regions count as illegal access
  assign region_now  = region_of(i_cpu_addr);
  assign illegal_now = i_cpu_addr_valid && (region_now == RG_GAP);

  // internal reset sources; watchdog, high voltage, high temperature and clock fail gated by the factory options
  assign int_src = i_rst_src.por || i_rst_src.low_voltage || illegal_now
                || (i_rst_src.watchdog     && opt_reg.watchdog_en)
                || (i_rst_src.high_voltage && opt_reg.hv_rst_en)
                || (i_rst_src.high_temp    && opt_reg.ht_rst_en)
                || (i_rst_src.clock_fail   && opt_reg.clk_mon_en);

  // stretch keeps the pin low long enough for board logic to see it
  assign hold_next    = int_src ? 7'(`PSR_RST_HOLD_CYC) :
                        (hold_reg != 7'h00) ? hold_reg - 7'h01 : 7'h00;
  assign drive_next   = int_src || (hold_reg != 7'h00);
  // filtered pin low or own drive holds the chip in reset
  assign sys_rst_next = drive_next || !pin_filt_reg;
  assign port_clr     = !o_sys_rst_n;

  // options caught only while i_rstn is held low; pin and internal resets keep them
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      opt_reg <= i_mask_opt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_int_clk <= 1'b0;
    end else begin
      o_int_clk <= ~o_int_clk;
    end
  end

  // reset pin filter, stands in for the schmitt input
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      pin_filt_reg <= 1'b1;
      pin_cnt_reg  <= 2'h0;
    end else if (i_reset_pin_in == pin_filt_reg) begin
      pin_cnt_reg <= 2'h0;
    end else if (pin_cnt_reg == 2'(`PSR_PIN_FILT_CYC - 1)) begin
      pin_cnt_reg  <= 2'h0;
      pin_filt_reg <= i_reset_pin_in;
    end else begin
      pin_cnt_reg <= pin_cnt_reg + 2'h1;
    end
  end

  // pin pull-down and chip reset outputs
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      hold_reg         <= 7'h00;
      o_reset_pin_out  <= 1'b0;
      o_reset_pin_oe_n <= 1'b0;
      o_sys_rst_n      <= 1'b0;
      o_mask_opt       <= '0;
    end else begin
      hold_reg         <= hold_next;
      o_reset_pin_out  <= 1'b0;
      o_reset_pin_oe_n <= ~drive_next;
      o_sys_rst_n      <= ~sys_rst_next;
      o_mask_opt       <= opt_reg;
    end
  end

  psr_irq_sense u_irq (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_irq_pin (i_irq_pin),
    .i_mode    (i_irq_mode),
    .o_irq_req (o_irq_req)
  );

  // software write strobes per port
  assign wr_a = i_port_wr.valid && (i_port_wr.port == PORT_A);
  assign wr_b = i_port_wr.valid && (i_port_wr.port == PORT_B);
  assign wr_c = i_port_wr.valid && (i_port_wr.port == PORT_C);

  // data and direction; any chip reset returns lines to input
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || port_clr) begin
      dir_a_reg <= `PSR_PA_RST;
      dir_b_reg <= `PSR_PB_RST;
      dir_c_reg <= `PSR_PC_RST;
      dat_a_reg <= `PSR_PA_RST;
      dat_b_reg <= `PSR_PB_RST;
      dat_c_reg <= `PSR_PC_RST;
    end else begin
      if (wr_a && i_port_wr.to_dir)  dir_a_reg <= i_port_wr.value;
      if (wr_a && !i_port_wr.to_dir) dat_a_reg <= i_port_wr.value;
      if (wr_b && i_port_wr.to_dir)  dir_b_reg <= i_port_wr.value[4:0];
      if (wr_b && !i_port_wr.to_dir) dat_b_reg <= i_port_wr.value[4:0];
      if (wr_c && i_port_wr.to_dir)  dir_c_reg <= i_port_wr.value[6:0];
      if (wr_c && !i_port_wr.to_dir) dat_c_reg <= i_port_wr.value[6:0];
    end
  end

  // bit 0 is converter_low_reference, bit 7 converter_high_reference
  assign analog_next = i_alt_cfg.pa_analog | (i_alt_cfg.opamp_en ? `PSR_PA_OPAMP : 8'h00);

  // per-line sharing for port b
  genvar gb;
  generate
    for (gb = 0; gb < 5; gb++) begin : g_pb
      logic [1:0] d;
      assign d = line_drive(dir_b_reg[gb], dat_b_reg[gb], i_alt_cfg.pb_timer[gb],
                            i_alt_cfg.pb_pwm[gb],
                            1'((`PSR_PB_CMP1 | `PSR_PB_CMP2) >> gb),
                            1'((`PSR_PB_CAP1 | `PSR_PB_CAP2) >> gb),
                            1'(`PSR_PB_PWM >> gb),
                            1'(`PSR_PB_CMP1 >> gb) ?
                              i_periph.compare_output_1 : i_periph.compare_output_2,
                            i_periph.pwm);
      assign pb_drv[gb] = d[1];
      assign pb_val[gb] = d[0];
    end
  endgenerate

  // per-line sharing for port c, relay lines 5 and 6 included
  genvar gc;
  generate
    for (gc = 0; gc < 7; gc++) begin : g_pc
      logic [1:0] d;
      assign d = line_drive(dir_c_reg[gc], dat_c_reg[gc], i_alt_cfg.pc_timer[gc],
                            i_alt_cfg.pc_pwm[gc],
                            1'((`PSR_PC_CMP1 | `PSR_PC_CMP2) >> gc),
                            1'((`PSR_PC_CAP1 | `PSR_PC_CAP2) >> gc),
                            1'(`PSR_PC_PWM >> gc),
                            1'(`PSR_PC_CMP1 >> gc) ?
                              i_periph.compare_output_1 : i_periph.compare_output_2,
                            i_periph.pwm);
      assign pc_drv[gc] = d[1];
      assign pc_val[gc] = d[0];
    end
  endgenerate

  // capture routing; port b wins, port c lines selected together are or-ed
  assign pb_cap1_act = i_alt_cfg.pb_timer & ~i_alt_cfg.pb_pwm & `PSR_PB_CAP1;
  assign pb_cap2_act = i_alt_cfg.pb_timer & ~i_alt_cfg.pb_pwm & `PSR_PB_CAP2;
  assign pc_cap1_act = i_alt_cfg.pc_timer & ~i_alt_cfg.pc_pwm & `PSR_PC_CAP1 & ~dir_c_reg;
  assign pc_cap2_act = i_alt_cfg.pc_timer & ~i_alt_cfg.pc_pwm & `PSR_PC_CAP2 & ~dir_c_reg;
  assign cap1_next   = (|pb_cap1_act) ? |(i_pb_in & pb_cap1_act) : |(i_pc_in & pc_cap1_act);
  assign cap2_next   = (|pb_cap2_act) ? |(i_pb_in & pb_cap2_act) : |(i_pc_in & pc_cap2_act);

  // registered pin outputs; reset forces every enable off at once
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || port_clr) begin
      o_pa_out          <= 8'h00;
      o_pa_oe_n         <= 8'hFF;
      o_pa_analog_en    <= 8'h00;
      o_pb_out          <= 5'h00;
      o_pb_oe_n         <= 5'h1F;
      o_pc_out          <= 7'h00;
      o_pc_oe_n         <= 7'h7F;
      o_capture_input_1 <= 1'b0;
      o_capture_input_2 <= 1'b0;
    end else begin
      o_pa_out          <= dat_a_reg;
      o_pa_oe_n         <= ~(dir_a_reg & ~analog_next);
      o_pa_analog_en    <= analog_next;
      o_pb_out          <= pb_val;
      o_pb_oe_n         <= ~pb_drv;
      o_pc_out          <= pc_val;
      o_pc_oe_n         <= ~pc_drv;
      o_capture_input_1 <= cap1_next;
      o_capture_input_2 <= cap2_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_region       <= RG_IO;
      o_addr_illegal <= 1'b0;
    end else begin
      o_region       <= region_now;
      o_addr_illegal <= illegal_now;
    end
  end

  chk_clk_div_two : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ##1 1'b1 |-> o_int_clk != $past(o_int_clk))
    else $error("internal clock did not toggle");

  chk_pin_filter_rst : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (!i_reset_pin_in)[*3] |-> ##[1:2] !o_sys_rst_n)
    else $error("held reset pin did not reset chip");

  chk_pin_pull_low : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    int_src |=> !o_reset_pin_oe_n && !o_reset_pin_out && !o_sys_rst_n)
    else $error("internal reset did not pull pin low");

  chk_pa_dir_default : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !o_sys_rst_n |=> o_pa_oe_n == 8'hFF && dir_a_reg == 8'h00)
    else $error("port a not input after reset");

  chk_pa_analog_off : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_sys_rst_n && i_alt_cfg.opamp_en ##1 o_sys_rst_n |-> o_pa_oe_n[6:4] == 3'h7)
    else $error("op amp line still driven");

  chk_pb_dir_default : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !o_sys_rst_n |=> o_pb_oe_n == 5'h1F)
    else $error("port b not input after reset");

  chk_pb4_pwm : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_sys_rst_n && i_alt_cfg.pb_pwm[4] ##1 o_sys_rst_n
      |-> !o_pb_oe_n[4] && o_pb_out[4] == $past(i_periph.pwm))
    else $error("pb4 does not carry pwm");

  chk_pc_dir_default : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !o_sys_rst_n |=> o_pc_oe_n == 7'h7F)
    else $error("port c not input after reset");

  chk_pc6_relay_pwm : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_sys_rst_n && i_alt_cfg.pc_pwm[6] ##1 o_sys_rst_n
      |-> !o_pc_oe_n[6] && o_pc_out[6] == $past(i_periph.pwm))
    else $error("pc6 does not carry pwm");

  chk_wdog_opt_gate : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_rst_src == 6'h10 && !opt_reg.watchdog_en && !illegal_now && hold_reg == 7'h00
      |=> o_reset_pin_oe_n)
    else $error("disabled watchdog still reset chip");

  chk_gap_illegal : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_cpu_addr_valid && i_cpu_addr == 14'h0100 |=> o_addr_illegal && o_region == RG_GAP)
    else $error("gap address not flagged");

  chk_cmp_drives_pb1 : assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_sys_rst_n && i_alt_cfg.pb_timer[1] && !i_alt_cfg.pb_pwm[1] ##1 o_sys_rst_n
      |-> !o_pb_oe_n[1] && o_pb_out[1] == $past(i_periph.compare_output_1))
    else $error("pb1 does not carry compare output");

endmodule : psr_glue

// ---- sim/psr_board.sv ----
// Purpose: board side of the pin glue - reset circuit and port loads
// Assumes: device enables are active low
// Notes:   port a floats high on pull-ups, b and c read the external load
`timescale 1ns/1ps
module psr_board (
  input  wire logic       i_rst_oe_n,
  input  wire logic       i_rst_out,
  input  wire logic       i_hold_low,
  input  wire logic [7:0] i_pa_out,
  input  wire logic [7:0] i_pa_oe_n,
  input  wire logic [4:0] i_pb_out,
  input  wire logic [4:0] i_pb_oe_n,
  input  wire logic [6:0] i_pc_out,
  input  wire logic [6:0] i_pc_oe_n,
  input  wire logic [4:0] i_pb_load,
  input  wire logic [6:0] i_pc_load,
  output logic            o_rst_pin,
  output logic [7:0]      o_pa_pin,
  output logic [4:0]      o_pb_pin,
  output logic [6:0]      o_pc_pin
);
  // board hold or device pull-down, else pull-up
  assign o_rst_pin = i_hold_low ? 1'b0 : (i_rst_oe_n ? 1'b1 : i_rst_out);
  // driven lines show device value, released lines the load, or high on port a
  assign o_pa_pin = (i_pa_out & ~i_pa_oe_n) | i_pa_oe_n;
  assign o_pb_pin = (i_pb_out & ~i_pb_oe_n) | (i_pb_load & i_pb_oe_n);
  assign o_pc_pin = (i_pc_out & ~i_pc_oe_n) | (i_pc_load & i_pc_oe_n);
endmodule : psr_board

// ---- sim/tb.sv ----
// Purpose: self-checking bench for the pin glue
// Assumes: inputs change 1 ns after the rising edge
// Notes:   reset stretch checked against the 640 ns define
`timescale 1ns/1ps
`include "psr_consts.svh"
module tb
  import psr_pkg::*;
;
  logic          clk, rstn, hold_low, irq_pin, av, ic, rpo, roe, srst, irq, ill, cap1, cap2, rpin;
  psr_rst_src_t  src;
  psr_mask_opt_t opt, mopt;
  psr_irq_mode_t mode;
  psr_port_wr_t  wr;
  psr_alt_cfg_t  alt;
  psr_periph_t   per;
  psr_region_t   rgn;
  logic [13:0]   addr;
  logic [7:0]    pa_out, pa_oe, pa_an, pa_pin, r, d;
  logic [4:0]    pb_out, pb_oe, pb_pin, pb_load;
  logic [6:0]    pc_out, pc_oe, pc_pin, pc_load;
  int            err_total, tests_run, seed, cycles;

  psr_glue dut_u (.i_ref_clk(clk), .i_rstn(rstn), .i_reset_pin_in(rpin), .i_rst_src(src),
    .i_mask_opt(opt), .i_irq_pin(irq_pin), .i_irq_mode(mode), .i_port_wr(wr), .i_alt_cfg(alt),
    .i_periph(per), .i_pa_in(pa_pin), .i_pb_in(pb_pin), .i_pc_in(pc_pin),
    .i_cpu_addr_valid(av), .i_cpu_addr(addr), .o_int_clk(ic), .o_reset_pin_out(rpo),
    .o_reset_pin_oe_n(roe), .o_sys_rst_n(srst), .o_irq_req(irq), .o_mask_opt(mopt),
    .o_pa_out(pa_out), .o_pa_oe_n(pa_oe), .o_pa_analog_en(pa_an), .o_pb_out(pb_out),
    .o_pb_oe_n(pb_oe), .o_pc_out(pc_out), .o_pc_oe_n(pc_oe), .o_capture_input_1(cap1),
    .o_capture_input_2(cap2), .o_region(rgn), .o_addr_illegal(ill));
  psr_board board_u (.i_rst_oe_n(roe), .i_rst_out(rpo), .i_hold_low(hold_low),
    .i_pa_out(pa_out), .i_pa_oe_n(pa_oe), .i_pb_out(pb_out), .i_pb_oe_n(pb_oe),
    .i_pc_out(pc_out), .i_pc_oe_n(pc_oe), .i_pb_load(pb_load), .i_pc_load(pc_load),
    .o_rst_pin(rpin), .o_pa_pin(pa_pin), .o_pb_pin(pb_pin), .o_pc_pin(pc_pin));

  // 100 MHz clock and a hang guard well past the expected run
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_rgn(input psr_region_t got, input psr_region_t exp);
    cmp({16'h0000, got}, {16'h0000, exp});
  endtask : cmp_rgn

  // one-cycle write strobe, then one idle edge so calls never meet in one step
  task automatic wr_port(input logic dr, input psr_port_t p, input logic [7:0] v);
    wr = '{1'b1, dr, p, v};
    cyc(1);
    wr.valid = 1'b0;
    cyc(1);
  endtask : wr_port

  // expected region from the address map ends
  function automatic psr_region_t rgn_of(input logic [13:0] a);
    if (a <= `PSR_IO_END) return RG_IO;
    if (a <= `PSR_EXT_END) return RG_EXT;
    if (a <= `PSR_RAM_END) return RG_RAM;
    if (a <= `PSR_GAP1_END) return RG_GAP;
    if (a <= `PSR_EE_END) return RG_EEPROM;
    if (a <= `PSR_GAP2_END) return RG_GAP;
    if (a == `PSR_OPT_ADDR) return RG_OPTION;
    if (a <= `PSR_PROG_END) return RG_PROGRAM;
    if (a <= `PSR_MON_END) return RG_MONITOR;
    return RG_VECTOR;
  endfunction : rgn_of

  // pin leaves level s, comes back after w+1 cycles, request cycles counted
  task automatic irq_try(input psr_irq_mode_t m, input logic s, input int w, input int lo,
                         input int hi);
    int k;
    k = 0;
    mode = m;
    irq_pin = s;
    cyc(8);
    irq_pin = ~s;
    for (int i = 0; i < 16; i++) begin
      cyc(1);
      if (i == w) irq_pin = s;
      k += int'(irq === 1'b1);
    end
    cmp(k >= lo && k <= hi, 1'b1);
  endtask : irq_try

  // one reset cause held 6 cycles, then recovery must leave port a as input
  task automatic rst_try(input psr_rst_src_t s, input logic hold, input logic [13:0] a);
    int k;
    int e;
    wr_port(1'b1, PORT_A, 8'hFF);
    cyc(1);
    src = s;
    hold_low = hold;
    av = |a;
    addr = a;
    cyc(6);
    cmp({srst, pa_oe}, 9'h0FF);
    if (!hold) cmp({roe, rpo}, 2'b00);
    src = '0;
    hold_low = 1'b0;
    av = 1'b0;
    k = 0;
    while (srst !== 1'b1 && k < 400) begin
      cyc(1);
      k++;
    end
    // board hold: filter only; own drive: stretch, then filter sees the pin rise
    e = hold ? `PSR_PIN_FILT_CYC + 1 : `PSR_RST_HOLD_CYC + `PSR_PIN_FILT_CYC + 2;
    cmp({srst, 19'(k)}, {1'b1, 19'(e)});
    cmp(pa_oe, 8'hFF);
    cyc(2);
  endtask : rst_try

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // main sequence: reset, then each sharing, irq, decode and reset case
  initial begin
    logic [13:0] al[13] = '{14'h0000, 14'h002F, 14'h0030, 14'h00C0, 14'h0180, 14'h01FF,
                           14'h2000, 14'h2001, 14'h3EFF, 14'h3F00, 14'h3FEF, 14'h3FF0, 14'h3FFF};
    seed = 15;
    {clk, rstn, hold_low, av, addr, src, wr, alt, per} = '0;
    {pb_load, pc_load, err_total, tests_run, cycles} = '0;
    mode = IRQ_RISE;
    irq_pin = 1'b1; // idle high, matches the filter's reset level
    // watchdog option off first, on after the mid-run reset
    opt = psr_mask_opt_t'((5'($random(seed)) | 5'h07) & 5'h17);
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    cyc(3);
    cmp(mopt, opt);
    cmp({pa_oe, pb_oe, pc_oe}, 20'hF_FFFF);
    for (int i = 0; i < 4; i++) begin
      r[0] = ic;
      cyc(1);
      cmp(ic, !r[0]);
    end
    // gated watchdog ignored, then a second reset latches it enabled
    src.watchdog = 1'b1;
    cyc(4);
    cmp({roe, srst}, 2'b11);
    src = '0;
    rstn = 1'b0;
    opt.watchdog_en = 1'b1;
    cyc(4);
    rstn = 1'b1;
    cyc(3);
    cmp({mopt, srst}, {opt, 1'b1});
    r = 8'($random(seed));
    d = 8'($random(seed));
    wr_port(1'b1, PORT_A, r);
    wr_port(1'b0, PORT_A, d);
    cyc(1);
    cmp({pa_oe, pa_out & r}, {~r, d & r});
    alt.pa_analog = 8'hFF;
    alt.opamp_en = 1'b1;
    cyc(2);
    cmp({pa_oe, pa_an}, 16'hFFFF);
    alt = '{pa_analog: 8'h00, opamp_en: 1'b0, pb_timer: 5'h0F, pb_pwm: 5'h10,
            pc_timer: 7'h0A, pc_pwm: 7'h61};
    wr_port(1'b1, PORT_B, 8'h1A);
    wr_port(1'b1, PORT_C, 8'h7F);
    for (int i = 0; i < 6; i++) begin
      per = psr_periph_t'(3'($random(seed)));
      pb_load = 5'($random(seed));
      cyc(2);
      cmp({pb_out[4], pc_out[6], pc_out[5], pc_out[0]}, {4{per.pwm}});
      cmp({pb_out[3], pb_out[1], pc_out[3], pc_out[1]},
          {per.compare_output_2, per.compare_output_1,
           per.compare_output_2, per.compare_output_1});
      cmp({cap1, cap2}, {pb_load[0], pb_load[2]});
    end
    alt = '0;
    irq_try(IRQ_RISE, 1'b0, 99, 1, 1);
    irq_try(IRQ_FALL, 1'b1, 99, 1, 1);
    irq_try(IRQ_HIGH, 1'b0, 99, 8, 16);
    irq_try(IRQ_LOW, 1'b1, 99, 8, 16);
    irq_try(IRQ_RISE, 1'b1, 99, 0, 0);
    irq_try(IRQ_RISE, 1'b0, 1, 0, 0);
    av = 1'b1;
    foreach (al[i]) begin
      addr = al[i];
      cyc(1);
      cmp_rgn(rgn, rgn_of(al[i]));
      cmp(ill, rgn_of(al[i]) == RG_GAP);
    end
    av = 1'b0;
    for (int i = 0; i < 6; i++) rst_try(psr_rst_src_t'(6'h01 << i), 1'b0, 14'h0000);
    rst_try('0, 1'b1, 14'h0000);
    rst_try('0, 1'b0, 14'h0100);
    print_verdict();
  end
endmodule : tb
